// file: fpp_prog_port.v
/*
  flash programming port: serial slave taking commands from a programmer.
  assumes a programmer-driven serial clock, sampled here by clk (125 MHz),
  and that the programmer keeps its own entry and exit spacing.
*/
`timescale 1ns/1ps
`include "fpp_regs.vh"
module fpp_prog_port #(
  parameter WRITE_CYC = `FPP_WRITE_CYC,
  parameter ERASE_CYC = `FPP_ERASE_CYC
) (
  input  wire        clk,                      // system clock
  input  wire        nrst,                     // reset pin, active low
  input  wire        prog_mode_select_n,       // programming mode request
  input  wire        prog_port_slave_select_n, // transaction frame
  input  wire        prog_port_serial_clock,   // serial clock
  input  wire        prog_port_data_in,        // serial data in
  output reg         prog_port_data_out,       // serial data out
  output wire        prog_port_data_out_oe,    // data out enable
  input  wire        fetch_req,                // core fetch request
  input  wire        fetch_bank,               // core fetch bank
  output wire        fetch_stall,              // core fetch stall
  output reg         prog_active,              // programming mode latched
  output wire        flash_busy,               // write or erase running
  output reg  [1:0]  flash_op,                 // operation to flash core
  output reg  [31:0] flash_addr,               // flash address
  output reg  [31:0] flash_data,               // word to write
  output wire        flash_done                // completion pulse
);
  reg        rst_s1;
  reg        rst_s2;
  reg [2:0]  ss_sync;
  reg [2:0]  sck_sync;
  reg [1:0]  mosi_sync;
  reg [1:0]  pm_sync;
  reg [7:0]  opcode;
  reg [31:0] shift;
  reg [6:0]  bitcnt;
  reg        start;
  reg [7:0]  tx;
  reg        seen_busy;
  // ==========================================
  // reset release through two flops
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  // ==========================================
  // pin synchronisers; only the second stage onward is read
  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      ss_sync   <= 3'h7;
      sck_sync  <= 3'h0;
      mosi_sync <= 2'h0;
    end
    else
    begin
      ss_sync   <= {ss_sync[1:0], prog_port_slave_select_n};
      sck_sync  <= {sck_sync[1:0], prog_port_serial_clock};
      mosi_sync <= {mosi_sync[0], prog_port_data_in};
    end
  end
  // mode select synchroniser runs through reset, because entry is sampled there
  always @(posedge clk)
  begin
    pm_sync <= {pm_sync[0], prog_mode_select_n};
  end
  wire ss_act = ~ss_sync[1];
  wire sck_re = sck_sync[1] & ~sck_sync[2];
  wire sck_fe = ~sck_sync[1] & sck_sync[2];
  wire ss_end = ss_sync[1] & ~ss_sync[2];
  // ==========================================
  // mode select is caught while the pin reset is held, so it must lead reset
  // limitation: select must stand two clocks before the internal reset lifts
  always @(posedge clk)
  begin
    if (!rst_s2)
      prog_active <= ~pm_sync[1];
    else if (pm_sync[1])
      prog_active <= 1'b0;
  end
  // ==========================================
  // shift in opcode, address, data; issue operation at frame end
  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      opcode     <= 8'h00;
      shift      <= 32'h0000_0000;
      bitcnt     <= 7'h00;
      flash_addr <= 32'h0000_0000;
      flash_data <= 32'h0000_0000;
      flash_op   <= 2'h0;
      start      <= 1'b0;
      seen_busy  <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      // a frame that overlaps a running operation is refused as a whole
      if (!ss_act)
        seen_busy <= 1'b0;
      else if (flash_busy)
        seen_busy <= 1'b1;
      if (!ss_act)
        bitcnt <= 7'h00;
      else if (sck_re && prog_active)
      begin
        shift  <= {shift[30:0], mosi_sync[1]};
        bitcnt <= (bitcnt == 7'h48) ? bitcnt : bitcnt + 7'h01;
        if (bitcnt == 7'h07)
          opcode <= {shift[6:0], mosi_sync[1]};
        // address and data stay put while the core works on them
        if (bitcnt == 7'h27 && !flash_busy)
          flash_addr <= {shift[30:0], mosi_sync[1]};
        if (bitcnt == 7'h47 && !flash_busy)
          flash_data <= {shift[30:0], mosi_sync[1]};
      end
      // busy port refuses new work
      if (ss_end && prog_active && !flash_busy && !seen_busy)
      begin
        start <= 1'b1;
        case (opcode)
          `FPP_OP_WRITE:      flash_op <= (bitcnt == 7'h48) ? `FPP_FOP_WRITE : `FPP_FOP_NONE;
          `FPP_OP_PAGE_ERASE: flash_op <= (bitcnt >= 7'h28) ? `FPP_FOP_PAGE : `FPP_FOP_NONE;
          `FPP_OP_MASS_ERASE: flash_op <= (bitcnt >= 7'h08) ? `FPP_FOP_MASS : `FPP_FOP_NONE;
          default:            flash_op <= `FPP_FOP_NONE;
        endcase
      end
    end
  end
  // ==========================================
  // status byte out on falling edges: bit0 busy, bit1 mode active
  always @(posedge clk or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      tx                 <= 8'h00;
      prog_port_data_out <= 1'b0;
    end
    else if (!ss_act)
    begin
      tx                 <= {6'h00, prog_active, flash_busy};
      prog_port_data_out <= 1'b0;
    end
    else if (sck_fe && bitcnt >= 7'h08 && opcode == `FPP_OP_STATUS)
    begin
      prog_port_data_out <= tx[7];
      tx                 <= {tx[6:0], 1'b0};
    end
  end
  assign prog_port_data_out_oe = ss_act & prog_active;
  // ==========================================
  // bank from address bit 18 (256 KB banks)
  fpp_flash_timer #(
    .WRITE_CYC (WRITE_CYC),
    .ERASE_CYC (ERASE_CYC)
  ) u_timer (
    .clk         (clk),
    .rst_n       (rst_s2),
    .start       (start),
    .op          (flash_op),
    .bank        (flash_addr[18]),
    .fetch_req   (fetch_req),
    .fetch_bank  (fetch_bank),
    .busy        (flash_busy),
    .cur_op      (),
    .done        (flash_done),
    .fetch_stall (fetch_stall)
  );
endmodule // fpp_prog_port

// file: fpp_regs.vh
/*
  constants for the flash programming port: timing figures, serial opcodes, flash operation codes.
  assumes the including module runs on a 125 MHz clock.
*/
// Notes on behaviour
// - word write finishes within 21 us
// - page erase finishes within 21 ms
// - bank mass erase finishes within 21 ms
// - stall fetches from bank during operation
`ifndef FPP_REGS_VH
`define FPP_REGS_VH
// ==========================================
// timing
`define FPP_CLK_MHZ        125
`define FPP_WRITE_MAX_US   21
`define FPP_ERASE_MAX_MS   21
`define FPP_WRITE_CYC      (`FPP_WRITE_MAX_US * `FPP_CLK_MHZ)
`define FPP_ERASE_CYC      (`FPP_ERASE_MAX_MS * 1000 * `FPP_CLK_MHZ)
// ==========================================
// serial opcodes
`define FPP_OP_WRITE       8'h02
`define FPP_OP_PAGE_ERASE  8'h20
`define FPP_OP_MASS_ERASE  8'hC7
`define FPP_OP_STATUS      8'h05
// ==========================================
// operation codes to the flash core
`define FPP_FOP_NONE       2'h0
`define FPP_FOP_WRITE      2'h1
`define FPP_FOP_PAGE       2'h2
`define FPP_FOP_MASS       2'h3
`endif

// file: fpp_flash_timer.v
/*
  flash operation sequencer: times one write or erase and stalls fetches.
  assumes requests arrive as one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`include "fpp_regs.vh"
module fpp_flash_timer #(
  parameter WRITE_CYC = `FPP_WRITE_CYC,
  parameter ERASE_CYC = `FPP_ERASE_CYC
) (
  input  wire        clk,        // system clock
  input  wire        rst_n,      // synchronised reset
  input  wire        start,      // request pulse
  input  wire [1:0]  op,         // operation code
  input  wire        bank,       // target bank
  input  wire        fetch_req,  // instruction fetch request
  input  wire        fetch_bank, // bank of the fetch
  output reg         busy,       // operation running
  output reg  [1:0]  cur_op,     // operation in progress
  output reg         done,       // completion pulse
  output wire        fetch_stall // fetch held off
);
  reg [23:0] count;
  reg        cur_bank;
  // ==========================================
  // one operation at a time; new starts ignored while busy
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy     <= 1'b0;
      count    <= 24'h00_0000;
      cur_op   <= 2'h0;
      cur_bank <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start && op != `FPP_FOP_NONE)
      begin
        busy     <= 1'b1;
        cur_op   <= op;
        cur_bank <= bank;
        count    <= (op == `FPP_FOP_WRITE) ? WRITE_CYC[23:0] - 24'h00_0001
                                           : ERASE_CYC[23:0] - 24'h00_0001;
      end
      else if (busy)
      begin
        if (count == 24'h00_0000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          count <= count - 24'h00_0001;
      end
    end
  end
  // only fetches aimed at the busy bank wait
  assign fetch_stall = busy && fetch_req && (fetch_bank == cur_bank);
endmodule // fpp_flash_timer

// file: fpp_prog_port_sva.sv
/* checker for the flash programming port.
   assumes binding to fpp_prog_port with its own cycle counts. */
`timescale 1ns/1ps
module fpp_prog_port_sva #(
  parameter WRITE_CYC = 20,
  parameter ERASE_CYC = 200
) (
  input wire        clk,         // clock
  input wire        nrst,        // reset pin
  input wire        fetch_req,   // fetch
  input wire        fetch_bank,  // fetch bank
  input wire        fetch_stall, // stall
  input wire        flash_busy,  // busy
  input wire [1:0]  flash_op,    // operation
  input wire [31:0] flash_addr,  // address
  input wire        flash_done   // done pulse
);
  reg [31:0] cnt;
  // busy length; a busy that never ends trips the time checks
  always @(posedge clk or negedge nrst)
    if (!nrst)
      cnt <= 32'h0000_0000;
    else
      cnt <= flash_busy ? cnt + 32'h0000_0001 : 32'h0000_0000;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_write_time: assert property (flash_busy && flash_op == 2'h1 |-> cnt < WRITE_CYC)
    else $error("word write too long");
  chk_erase_time: assert property (flash_busy && flash_op[1] |-> cnt < ERASE_CYC)
    else $error("erase too long");
  chk_fetch_held: assert property (flash_busy && fetch_req && fetch_bank == flash_addr[18]
    |-> fetch_stall)
    else $error("fetch not stalled");
  chk_idle_free: assert property (!flash_busy |-> !fetch_stall)
    else $error("stall while idle");
  chk_op_held: assert property (flash_busy && !flash_done |=> $stable(flash_op))
    else $error("operation changed while busy");
  chk_done_pulse: assert property (flash_done |=> !flash_done)
    else $error("done longer than one cycle");
  cover property (flash_done && flash_op == 2'h1);
  cover property (flash_done && flash_op[1]);
  cover property (fetch_stall);
endmodule // fpp_prog_port_sva
bind fpp_prog_port fpp_prog_port_sva #(.WRITE_CYC(WRITE_CYC), .ERASE_CYC(ERASE_CYC)) sva_i (
  .clk(clk), .nrst(nrst), .fetch_req(fetch_req), .fetch_bank(fetch_bank),
  .fetch_stall(fetch_stall), .flash_busy(flash_busy), .flash_op(flash_op),
  .flash_addr(flash_addr), .flash_done(flash_done));

// file: fpp_programmer.sv
/* programmer model: serial master, reset and mode pins.
   assumes calls start just after a clk edge; serial clock 80 ns. */
`timescale 1ns/1ps
module fpp_programmer (
  output reg  nrst,                     // reset pin
  output reg  prog_mode_select_n,       // mode request
  output reg  prog_port_slave_select_n, // frame
  output reg  prog_port_serial_clock,   // serial clock
  output reg  prog_port_data_in,        // data to device
  input  wire prog_port_data_out        // data from device
);
  reg [7:0] rx;
  // mode request no later than reset, both at time zero
  initial
  begin
    prog_mode_select_n = 1'b0;
    nrst = 1'b0;
    prog_port_slave_select_n = 1'b1;
    prog_port_serial_clock = 1'b0;
    prog_port_data_in = 1'b0;
  end
  // reset held six cycles, first frame no sooner than 125 us after reset asserts at time zero
  task enter;
    begin
      #45 nrst = 1'b1;
      #124955;
    end
  endtask
  // msb first; clock stands low and data toggles outside frames
  task frame(input [71:0] b, input [6:0] n);
    integer i;
    begin
      prog_port_slave_select_n = 1'b0;
      for (i = 0; i < n; i = i + 1)
      begin
        prog_port_data_in = b[71 - i];
        #40 prog_port_serial_clock = 1'b1;
        rx = {rx[6:0], prog_port_data_out};
        #40 prog_port_serial_clock = 1'b0;
      end
      #40 prog_port_slave_select_n = 1'b1;
      prog_port_data_in = ~prog_port_data_in;
      // select stays high a while so back-to-back frames stay apart
      #40;
    end
  endtask
  task leave;
    #10000 prog_mode_select_n = 1'b1;
  endtask
endmodule // fpp_programmer

// file: fpp_prog_port_tb.sv
/* self-checking bench for fpp_prog_port.
   assumes short cycle counts: 20 for a write, 400 for erases. */
`timescale 1ns/1ps
module fpp_prog_port_tb;
  reg clk, fetch_req, fetch_bank;
  wire nrst, msel_n, ss_n, sck, din, dout, oe, stall, active, busy, done;
  wire [1:0] op;
  wire [31:0] addr, data;
  integer mismatches, n_tests, cyc;
  fpp_programmer fpp_programmer_i (.nrst(nrst), .prog_mode_select_n(msel_n),
    .prog_port_slave_select_n(ss_n), .prog_port_serial_clock(sck),
    .prog_port_data_in(din), .prog_port_data_out(dout));
  fpp_prog_port #(.WRITE_CYC(20), .ERASE_CYC(400)) fpp_prog_port_i (.clk(clk), .nrst(nrst),
    .prog_mode_select_n(msel_n), .prog_port_slave_select_n(ss_n),
    .prog_port_serial_clock(sck), .prog_port_data_in(din), .prog_port_data_out(dout),
    .prog_port_data_out_oe(oe), .fetch_req(fetch_req), .fetch_bank(fetch_bank),
    .fetch_stall(stall), .prog_active(active), .flash_busy(busy), .flash_op(op),
    .flash_addr(addr), .flash_data(data), .flash_done(done));
  always #4 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cycles(input integer n);
    repeat (n) @(posedge clk) #1;
  endtask
  // bounded wait for done; frame end adds a few sync cycles
  task wait_done(input integer lim);
    integer c;
    begin
      c = 0;
      while (done !== 1'b1 && c < lim + 8)
      begin
        cycles(1);
        c = c + 1;
      end
      chk({31'h0, c < lim + 8}, 1);
    end
  endtask
  task t_write;
    begin
      fetch_req = 1'b1;
      fpp_programmer_i.frame({8'h02, 32'h0000_0010, 32'hCAFE_0001}, 72);
      cycles(6);
      chk(busy, 1);
      chk(stall, 1);
      fetch_bank = 1'b1;
      cycles(1);
      chk(stall, 0);
      chk(addr, 32'h0000_0010);
      chk(data, 32'hCAFE_0001);
      wait_done(20);
      chk(op, 1);
      cycles(2);
      chk(stall, 0);
      $display("t_write done");
    end
  endtask
  task t_page;
    begin
      fpp_programmer_i.frame({8'h20, 32'h0004_0000, 32'h0000_0000}, 40);
      cycles(6);
      chk(op, 2);
      fpp_programmer_i.frame({8'h05, 64'h0}, 16);
      chk(fpp_programmer_i.rx, 8'h03);
      fpp_programmer_i.frame({8'hC7, 64'h0}, 8);
      wait_done(400);
      chk(op, 2);
      $display("t_page done");
    end
  endtask
  task t_mass;
    begin
      cycles(4);
      fpp_programmer_i.frame({8'hC7, 64'h0}, 8);
      wait_done(400);
      chk(op, 3);
      fpp_programmer_i.frame({8'hC7, 64'h0}, 4);
      cycles(6);
      chk(busy, 0);
      fpp_programmer_i.frame({8'h05, 64'h0}, 16);
      chk(fpp_programmer_i.rx, 8'h02);
      chk(oe, 0);
      $display("t_mass done");
    end
  endtask
  task end_sim;
    begin
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    fetch_req = 1'b0;
    fetch_bank = 1'b0;
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    fpp_programmer_i.enter;
    cycles(1);
    chk(active, 1);
    t_write;
    t_page;
    t_mass;
    fpp_programmer_i.leave;
    cycles(6);
    chk(active, 0);
    end_sim;
  end
endmodule // fpp_prog_port_tb
